/* File: status_pkg.sv */
/*
 holds the register offsets, field positions, reset values and carriers
 of the status and service request block.
 assumes a single 250 MHz core clock and a plain strobe register port.
*/
package status_pkg;

   // register word offsets on the plain port
   localparam logic [3:0] STATUS_BYTE_OFS   = 4'h0;  // read: status byte (query form)
   localparam logic [3:0] SERVICE_EN_OFS    = 4'h1;  // rw: status byte enable mask
   localparam logic [3:0] STD_EVENT_OFS     = 4'h2;  // read clears: standard event
   localparam logic [3:0] STD_ENABLE_OFS    = 4'h3;  // rw: standard event enable
   localparam logic [3:0] QUESTIONABLE_SUMMARY_COND_OFS     = 4'h4;  // read: live regulation state
   localparam logic [3:0] QUESTIONABLE_SUMMARY_EVENT_OFS    = 4'h5;  // read clears: questionable event
   localparam logic [3:0] QUESTIONABLE_SUMMARY_ENABLE_OFS   = 4'h6;  // rw: questionable enable
   localparam logic [3:0] POWER_CLEAR_OFS   = 4'h7;  // rw: power-on clear setting
   localparam logic [3:0] ERROR_QUEUE_OFS   = 4'h8;  // read pops: error queue head
   localparam logic [3:0] ERROR_COUNT_OFS   = 4'h9;  // read: error queue fill
   localparam logic [3:0] COMMAND_OFS       = 4'ha;  // write: command code
   localparam logic [3:0] SERIAL_POLL_OFS   = 4'hb;  // read: serial poll status byte

   // command codes written to the command register
   localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h01;
   localparam logic [7:0] CMD_OPC           = 8'h02;
   localparam logic [7:0] CMD_OPC_QUERY     = 8'h03;
   localparam logic [7:0] CMD_WAIT          = 8'h04;
   localparam logic [7:0] CMD_STB_QUERY     = 8'h05;

   // status byte bit positions
   localparam int QUESTIONABLE_SUMMARY_SUM_BIT    = 3;
   localparam int MSG_WAIT_BIT    = 4;
   localparam int STD_SUM_BIT     = 5;
   localparam int SERVICE_BIT     = 6;

   // standard event bit positions
   localparam int OPC_BIT         = 0;
   localparam int QUERY_ERR_BIT   = 2;
   localparam int DEVICE_ERR_BIT  = 3;
   localparam int EXEC_ERR_BIT    = 4;
   localparam int CMD_ERR_BIT     = 5;
   localparam int POWER_ON_BIT    = 7;
   localparam logic [7:0] STD_USED_MASK  = 8'hbd;
   localparam logic [7:0] STB_SUM_MASK   = 8'h38;

   // questionable condition values
   localparam logic [1:0] REG_OFF    = 2'h0;
   localparam logic [1:0] REG_CC     = 2'h1;
   localparam logic [1:0] REG_CV     = 2'h2;
   localparam logic [1:0] REG_FAIL   = 2'h3;

   // error queue geometry and reset values
   localparam int          ERR_DEPTH   = 20;
   localparam logic [4:0]  ERR_LAST    = 5'h13;
   localparam logic [4:0]  ERR_FULL    = 5'h14;
   localparam logic [15:0] ERR_NONE    = 16'h0000;
   localparam logic [7:0]  OPC_ANSWER  = 8'h01;
   localparam logic [15:0] ZERO_WORD   = 16'h0000;

   // command sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_WAIT_DONE,
      SEQ_WAIT_SPACE
   } seq_state_e;

   // inputs that report instrument events
   typedef struct packed {
      logic [1:0] regulation;   // live constant_current / constant_voltage state
      logic       query_error_flag;
      logic       device_error_flag;
      logic       execution_error_flag;
      logic       command_error_flag;
      logic       error_push;     // one-cycle pulse with error_code
      logic [15:0] error_code;
      logic       ops_pending;    // instrument operations still running
      logic       triggered_mode;
      logic       msg_in_buffer;  // output buffer holds response data
      logic       buffer_full;    // output buffer cannot take another response
   } event_in_s;

   // all state of the block except the error queue storage
   typedef struct packed {
      seq_state_e  seq;
      logic [7:0]  pending_cmd;
      logic [7:0]  std_event;
      logic [7:0]  std_enable;
      logic [7:0]  srv_enable;
      logic [1:0]  questionable_summary_event;
      logic [1:0]  questionable_summary_enable;
      logic        power_clear;
      logic        service;
      logic        srq;
      logic        first_cycle;
      logic [15:0] rdata;
      logic        busy;
      logic        resp_valid;
      logic [7:0]  resp_data;
      logic        err_ind;
      logic [4:0]  err_head;
      logic [4:0]  err_count;
   } status_state_s;

endpackage

/* File: status_service_request_logic.sv */
/*
 holds the status byte, event and enable registers, error queue, service
 request generation and command ordering of the remote interface.
 assumes synchronous event inputs, a master that never holds read and
 write strobes together, and a retained power-on clear bit restored
 through power_clear_saved at reset release.
*/
// The plain strobed port and the register addresses were decided locally.
// Notes on behaviour
// - status byte enable gates service request
// - service flag drives srq to controller
// - service cleared by poll or event read
// - poll returns byte, clears only service
// - byte query keeps service, waits ordering
// - message waiting follows output buffer data
// - twenty entry error queue, oldest first
// - questionable condition is live regulation state
// - questionable event latches, clears on read
// - questionable enable gates questionable summary
// - clear status clears events and byte
// - standard enable gates standard summary
// - standard event read returns used bits only
// - opc sets bit zero after queue drains
// - opc query returns one after execution
// - power clear setting resets masks at power
// - full output buffer stalls command processing
// - wait holds commands in triggered mode
// - status byte bits three to six
// - standard event bit layout, unused zero
// - standard read clears event and summary
`timescale 1ns/100ps
`default_nettype none
module status_service_request_logic
   import status_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [15:0]      rdata,
   input  wire event_in_s   events,
   input  wire logic        power_clear_saved,
   output logic             srq,
   output logic             cmd_busy,
   output logic             resp_valid,
   output logic [7:0]       resp_data,
   output logic             error_indicator
);

   status_state_s st_r;       // registered state
   status_state_s st_nxt;     // next state

   logic [15:0] err_mem_r [ERR_DEPTH];   // error queue storage
   logic [4:0]  err_tail;                // write slot of error queue
   logic [5:0]  tail_sum;                // unwrapped write slot, one bit spare for head + count
   logic        err_pop;                 // error queue read this cycle
   logic        err_push_ok;             // error accepted into queue
   logic        questionable_summary_sum;                // questionable summary
   logic        std_sum;                 // standard event summary
   logic [7:0]  stb_live;                // status byte without service bit
   logic [7:0]  stb_full;                // status byte with service bit
   logic        srv_cause;               // masked summary request
   logic        cmd_wr;                  // command register written
   logic [7:0]  cmd_now;                 // command to execute this cycle
   logic        cmd_go;                  // command may execute now

   // live summary bits and status byte
   always_comb begin
      questionable_summary_sum = |(st_r.questionable_summary_event & st_r.questionable_summary_enable);
      std_sum  = |(st_r.std_event & st_r.std_enable & STD_USED_MASK);
      stb_live = 8'h00;
      stb_live[QUESTIONABLE_SUMMARY_SUM_BIT] = questionable_summary_sum;
      stb_live[MSG_WAIT_BIT] = events.msg_in_buffer;
      stb_live[STD_SUM_BIT]  = std_sum;
      stb_full = stb_live;
      stb_full[SERVICE_BIT]  = st_r.service;
      srv_cause = |(stb_live & st_r.srv_enable & STB_SUM_MASK);
   end

   // error queue pointers
   always_comb begin
      err_pop     = rd_stb && (addr == ERROR_QUEUE_OFS) && (st_r.err_count != 5'h00);
      err_push_ok = events.error_push && ((st_r.err_count != ERR_FULL) || err_pop);
      // head 19 plus count 20 reaches 39, so the sum must not wrap at 5 bits
      tail_sum    = {1'b0, st_r.err_head} + {1'b0, st_r.err_count};
      err_tail    = (tail_sum > {1'b0, ERR_LAST}) ? 5'(tail_sum - {1'b0, ERR_FULL}) :
                    tail_sum[4:0];
   end

   // error queue storage, one slot per generate entry
   for (genvar i = 0; i < ERR_DEPTH; i++) begin : g_err
      always_ff @(posedge core_clk) begin
         if (err_push_ok && (err_tail == 5'(i))) begin
            err_mem_r[i] <= events.error_code;
         end
      end
   end

   // command selection: a new write or the held one
   always_comb begin
      cmd_wr  = wr_stb && (addr == COMMAND_OFS);
      cmd_now = (st_r.seq == SEQ_IDLE) ? wdata[7:0] : st_r.pending_cmd;
      cmd_go  = !events.buffer_full &&
                !(events.ops_pending &&
                  ((cmd_now == CMD_OPC) || (cmd_now == CMD_OPC_QUERY) ||
                   (cmd_now == CMD_STB_QUERY) ||
                   ((cmd_now == CMD_WAIT) && events.triggered_mode)));
   end

   // next state of the block except the error queue storage
   always_comb begin
      st_nxt = st_r;
      st_nxt.resp_valid  = 1'b0;
      st_nxt.first_cycle = 1'b0;
      st_nxt.rdata       = ZERO_WORD;

      // register reads with their side effects
      if (rd_stb) begin
         case (addr)
            STATUS_BYTE_OFS: st_nxt.rdata = {8'h00, stb_full};
            SERIAL_POLL_OFS: begin
               st_nxt.rdata   = {8'h00, stb_full};
               st_nxt.service = 1'b0;
            end
            SERVICE_EN_OFS:  st_nxt.rdata = {8'h00, st_r.srv_enable};
            STD_EVENT_OFS: begin
               st_nxt.rdata     = {8'h00, st_r.std_event & STD_USED_MASK};
               st_nxt.std_event = 8'h00;
               if (st_r.srv_enable[STD_SUM_BIT] && std_sum) begin
                  st_nxt.service = 1'b0;
               end
            end
            STD_ENABLE_OFS:  st_nxt.rdata = {8'h00, st_r.std_enable};
            QUESTIONABLE_SUMMARY_COND_OFS:   st_nxt.rdata = {14'h0000, events.regulation};
            QUESTIONABLE_SUMMARY_EVENT_OFS: begin
               st_nxt.rdata      = {14'h0000, st_r.questionable_summary_event};
               st_nxt.questionable_summary_event = 2'h0;
               if (st_r.srv_enable[QUESTIONABLE_SUMMARY_SUM_BIT] && questionable_summary_sum) begin
                  st_nxt.service = 1'b0;
               end
            end
            QUESTIONABLE_SUMMARY_ENABLE_OFS: st_nxt.rdata = {14'h0000, st_r.questionable_summary_enable};
            POWER_CLEAR_OFS: st_nxt.rdata = {15'h0000, st_r.power_clear};
            ERROR_QUEUE_OFS: begin
               st_nxt.rdata = (st_r.err_count != 5'h00) ? err_mem_r[st_r.err_head] : ERR_NONE;
               if (err_pop) begin
                  st_nxt.err_head = (st_r.err_head == ERR_LAST) ? 5'h00 :
                                    5'(st_r.err_head + 5'h01);
               end
            end
            ERROR_COUNT_OFS: st_nxt.rdata = {11'h000, st_r.err_count};
            default:         st_nxt.rdata = ZERO_WORD;   // unmapped reads zero
         endcase
      end

      // mask and setting writes
      if (wr_stb) begin
         case (addr)
            SERVICE_EN_OFS:  st_nxt.srv_enable  = wdata[7:0] & STB_SUM_MASK;
            STD_ENABLE_OFS:  st_nxt.std_enable  = wdata[7:0] & STD_USED_MASK;
            QUESTIONABLE_SUMMARY_ENABLE_OFS: st_nxt.questionable_summary_enable = wdata[1:0];
            POWER_CLEAR_OFS: st_nxt.power_clear = wdata[0];
            default: ;
         endcase
      end

      // command sequencing: execute now or hold until allowed
      if ((cmd_wr && (st_r.seq == SEQ_IDLE)) || (st_r.seq != SEQ_IDLE)) begin
         if (cmd_go) begin
            st_nxt.seq = SEQ_IDLE;
            case (cmd_now)
               CMD_CLEAR_STATUS: begin
                  st_nxt.std_event  = 8'h00;
                  st_nxt.questionable_summary_event = 2'h0;
                  st_nxt.service    = 1'b0;
                  st_nxt.err_count  = 5'h00;
                  st_nxt.err_head   = err_tail;  // a push in this cycle becomes the head
               end
               CMD_OPC:       st_nxt.std_event[OPC_BIT] = 1'b1;
               CMD_OPC_QUERY: begin
                  st_nxt.resp_valid = 1'b1;
                  st_nxt.resp_data  = OPC_ANSWER;
               end
               CMD_STB_QUERY: begin
                  st_nxt.resp_valid = 1'b1;
                  st_nxt.resp_data  = stb_full;
               end
               default: ;   // wait and unknown codes only order the stream
            endcase
         end else begin
            st_nxt.pending_cmd = cmd_now;
            st_nxt.seq = events.buffer_full ? SEQ_WAIT_SPACE : SEQ_WAIT_DONE;
         end
      end

      // hardware events latch; set wins over any clear above
      if (events.query_error_flag)     st_nxt.std_event[QUERY_ERR_BIT]  = 1'b1;
      if (events.device_error_flag)    st_nxt.std_event[DEVICE_ERR_BIT] = 1'b1;
      if (events.execution_error_flag) st_nxt.std_event[EXEC_ERR_BIT]   = 1'b1;
      if (events.command_error_flag)   st_nxt.std_event[CMD_ERR_BIT]    = 1'b1;
      if (st_r.first_cycle)            st_nxt.std_event[POWER_ON_BIT]   = 1'b1;
      st_nxt.questionable_summary_event = st_nxt.questionable_summary_event | events.regulation;

      // error queue occupancy
      if (err_push_ok && !err_pop) begin
         st_nxt.err_count = 5'(st_nxt.err_count + 5'h01);
      end else if (err_pop && !err_push_ok && (st_nxt.err_count != 5'h00)) begin
         st_nxt.err_count = 5'(st_nxt.err_count - 5'h01);   // clear status may have emptied it
      end
      st_nxt.err_ind = (st_nxt.err_count != 5'h00);

      // service flag sets on a fresh masked summary
      if (srv_cause && !st_r.srq) begin
         st_nxt.service = 1'b1;
      end
      st_nxt.srq  = srv_cause;
      st_nxt.busy = (st_nxt.seq != SEQ_IDLE);

      // power-up mask handling from retained setting
      if (st_r.first_cycle) begin
         st_nxt.power_clear = power_clear_saved;
         if (power_clear_saved) begin
            st_nxt.srv_enable = 8'h00;
            st_nxt.std_enable = 8'h00;
         end
      end
   end

   // state register; first_cycle marks power-up
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.seq <= SEQ_IDLE;
         st_r.first_cycle <= 1'b1;
         // service and standard enable masks are retained storage; the power-up step clears them only
         // when the saved setting asks for it
         st_r.srv_enable <= st_r.srv_enable;
         st_r.std_enable <= st_r.std_enable;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state flops
   assign rdata           = st_r.rdata;
   assign srq             = st_r.service;
   assign cmd_busy        = st_r.busy;
   assign resp_valid      = st_r.resp_valid;
   assign resp_data       = st_r.resp_data;
   assign error_indicator = st_r.err_ind;

endmodule
`default_nettype wire

/* File: status_props.sv */
/*
 checker of the status block ports.
 assumes the single core clock and the package carriers; bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module status_props
   import status_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   input  wire logic [15:0] rdata,
   input  wire event_in_s   events,
   input  wire logic        srq,
   input  wire logic        cmd_busy,
   input  wire logic        resp_valid,
   input  wire logic [7:0]  resp_data
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // read strobe on one offset
   sequence s_rd(logic [3:0] a);
      rd_stb && addr == a;
   endsequence
   // command write that finds the block free
   sequence s_cmd(logic [7:0] c);
      wr_stb && addr == COMMAND_OFS && wdata[7:0] == c && !cmd_busy && !events.buffer_full;
   endsequence
   // questionable event read with regulation off
   sequence s_qrd;
      s_rd(QUESTIONABLE_SUMMARY_EVENT_OFS) ##0 events.regulation == REG_OFF;
   endsequence
   a_read_idle_zero: assert property (!rd_stb |=> rdata == ZERO_WORD)
      else $error("read data not zero outside a read");
   a_poll_layout: assert property (
      s_rd(SERIAL_POLL_OFS) |=> rdata[15:7] == 9'h000 && rdata[2:0] == 3'h0)
      else $error("serial poll unused bits set");
   a_poll_clears_srq: assert property (s_rd(SERIAL_POLL_OFS) |-> ##2 !srq)
      else $error("srq still high after serial poll");
   a_msg_wait_live: assert property (
      s_rd(STATUS_BYTE_OFS) |=> rdata[MSG_WAIT_BIT] == $past(events.msg_in_buffer))
      else $error("message waiting bit wrong");
   a_cond_live: assert property (
      s_rd(QUESTIONABLE_SUMMARY_COND_OFS) |=> rdata == {14'h0000, $past(events.regulation)})
      else $error("condition read not live");
   a_opc_answer: assert property (
      s_cmd(CMD_OPC_QUERY) ##0 !events.ops_pending |=> resp_valid && resp_data == OPC_ANSWER)
      else $error("opc query answer wrong");
   a_full_holds: assert property (cmd_busy && events.buffer_full |=> cmd_busy)
      else $error("command ran with buffer full");
   a_wait_holds: assert property (
      s_cmd(CMD_WAIT) ##0 (events.triggered_mode && events.ops_pending) |=> cmd_busy)
      else $error("wait did not hold commands");
   a_questionable_summary_clear: assert property (
      events.regulation == REG_OFF ##1 s_qrd ##1 events.regulation == REG_OFF ##1 s_qrd
      |=> rdata == ZERO_WORD)
      else $error("questionable event not cleared by read");
   a_std_layout: assert property (
      s_rd(STD_EVENT_OFS) |=> rdata[1] == 1'b0 && rdata[6] == 1'b0 && rdata[15:8] == 8'h00)
      else $error("standard event unused bits set");
endmodule
bind status_service_request_logic status_props status_props_inst (.core_clk, .rst_b, .addr,
   .wdata, .wr_stb, .rd_stb, .rdata, .events, .srq, .cmd_busy, .resp_valid, .resp_data);
`default_nettype wire

/* File: response_buffer_model.sv */
/*
 output buffer read by the bus controller, filled by command responses.
 assumes one response per resp_valid pulse and pops from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module response_buffer_model #(
   parameter int DEPTH = 2  // responses held before full
) (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       resp_valid,
   input  wire logic [7:0] resp_data,
   input  wire logic       pop,
   output logic [7:0]      head,
   output logic            msg_in_buffer,
   output logic            buffer_full
);
   logic [7:0] q[$];  // waiting responses, oldest first
   // oldest leaves on pop; head inverts every cycle while empty, so it matches stale data only on alternate cycles
   always @(posedge core_clk) begin
      if (!rst_b) begin
         q.delete();
         head <= 8'h00;
      end else begin
         if (pop && q.size() != 0) begin
            void'(q.pop_front());
         end
         if (resp_valid) begin
            q.push_back(resp_data);
         end
         head <= (q.size() != 0) ? q[0] : ~head;
      end
      msg_in_buffer <= (q.size() != 0);
      buffer_full   <= (q.size() >= DEPTH);
   end
endmodule
`default_nettype wire

/* File: status_service_request_logic_tb_top.sv */
/*
 bench of the status block: register port tasks and rule sequences.
 assumes the checker bind and the response buffer model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module status_service_request_logic_tb_top
   import status_pkg::*;
;
   logic        core_clk, rst_b, wr_stb, rd_stb, pcs, pop, srq, cmd_busy;
   logic        resp_valid, err_ind, message_waiting_flag, full;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata;
   logic [7:0]  head, resp_data;
   event_in_s   ev, ev_w;
   int          n_mismatch, n_checks, i;
   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;
   // buffer flags come from the model
   always_comb begin
      ev_w = ev;
      ev_w.msg_in_buffer = message_waiting_flag;
      ev_w.buffer_full = full;
   end
   status_service_request_logic status_service_request_logic_inst (.core_clk, .rst_b, .addr,
      .wdata, .wr_stb, .rd_stb, .rdata, .events(ev_w), .power_clear_saved(pcs), .srq,
      .cmd_busy, .resp_valid, .resp_data, .error_indicator(err_ind));
   response_buffer_model response_buffer_model_inst (.core_clk, .rst_b, .resp_valid,
      .resp_data, .pop, .head, .msg_in_buffer(message_waiting_flag), .buffer_full(full));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t flag %b expected %b", $time, g, e);
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge core_clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(COMMAND_OFS, {8'h00, c});
   endtask
   // bounded wait for the held command to run
   task automatic wait_idle;
      for (int k = 0; k < 64 && cmd_busy !== 1'b0; k++) begin
         @(posedge core_clk);
         #1;
      end
      settle();
      chk1(cmd_busy, 1'b0);
   endtask
   task automatic take;
      @(posedge core_clk);
      pop <= 1'b1;
      @(posedge core_clk);
      pop <= 1'b0;
      settle();
   endtask
   task automatic pwr(input logic s);
      @(posedge core_clk);
      rst_b <= 1'b0;
      pcs <= s;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      settle();
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #80000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      {rst_b, wr_stb, rd_stb, pop, addr, wdata, ev, n_mismatch, n_checks} = '0;
      pcs = 1'b1;
      pwr(1'b1);
      rdc(STD_EVENT_OFS, 16'h0080);
      rdc(STD_EVENT_OFS, 16'h0000);
      rdc(POWER_CLEAR_OFS, 16'h0001);
      wr(SERVICE_EN_OFS, 16'h0020);
      pwr(1'b0);
      rdc(SERVICE_EN_OFS, 16'h0020);
      pwr(1'b1);
      rdc(SERVICE_EN_OFS, 16'h0000);
      cmd(CMD_CLEAR_STATUS);
      wait_idle();
      wr(STD_ENABLE_OFS, 16'h00ff);
      rdc(STD_ENABLE_OFS, {8'h00, STD_USED_MASK});
      wr(STD_ENABLE_OFS, 16'h0001);
      wr(SERVICE_EN_OFS, 16'h0020);
      cmd(CMD_OPC_QUERY);
      wait_idle();
      rdc(STATUS_BYTE_OFS, 16'h0010);
      chk({8'h00, head}, {8'h00, OPC_ANSWER});
      take();
      rdc(STATUS_BYTE_OFS, 16'h0000);
      ev.ops_pending <= 1'b1;
      cmd(CMD_OPC);
      settle();
      chk1(cmd_busy, 1'b1);
      chk1(srq, 1'b0);
      ev.ops_pending <= 1'b0;
      wait_idle();
      chk1(srq, 1'b1);
      rdc(STATUS_BYTE_OFS, 16'h0060);
      rdc(SERIAL_POLL_OFS, 16'h0060);
      settle();
      chk1(srq, 1'b0);
      rdc(STATUS_BYTE_OFS, 16'h0020);
      rdc(STD_EVENT_OFS, 16'h0001);
      rdc(STATUS_BYTE_OFS, 16'h0000);
      // an enabled event whose summary is masked off the request
      wr(SERVICE_EN_OFS, 16'h0000);
      wr(STD_ENABLE_OFS, 16'h0010);
      ev.execution_error_flag <= 1'b1;
      @(posedge core_clk);
      ev.execution_error_flag <= 1'b0;
      settle();
      chk1(srq, 1'b0);
      rdc(STATUS_BYTE_OFS, 16'h0020);
      cmd(CMD_CLEAR_STATUS);
      wait_idle();
      rdc(STATUS_BYTE_OFS, 16'h0000);
      rdc(STD_EVENT_OFS, 16'h0000);
      // every regulation code, read live
      for (i = 0; i < 4; i++) begin
         ev.regulation <= i[1:0];
         rdc(QUESTIONABLE_SUMMARY_COND_OFS, {14'h0000, i[1:0]});
      end
      ev.regulation <= REG_OFF;
      wr(QUESTIONABLE_SUMMARY_ENABLE_OFS, 16'h0003);
      rdc(QUESTIONABLE_SUMMARY_ENABLE_OFS, 16'h0003);
      rdc(STATUS_BYTE_OFS, 16'h0008);
      rdc(QUESTIONABLE_SUMMARY_EVENT_OFS, 16'h0003);
      rdc(QUESTIONABLE_SUMMARY_EVENT_OFS, 16'h0000);
      rdc(STATUS_BYTE_OFS, 16'h0000);
      // one push past the queue depth is dropped
      for (i = 0; i < 21; i++) begin
         @(posedge core_clk);
         ev.error_push <= 1'b1;
         ev.error_code <= 16'(i + 1);
         @(posedge core_clk);
         ev.error_push <= 1'b0;
      end
      settle();
      chk1(err_ind, 1'b1);
      rdc(ERROR_COUNT_OFS, 16'h0014);
      for (i = 0; i < 20; i++) rdc(ERROR_QUEUE_OFS, 16'(i + 1));
      rdc(ERROR_QUEUE_OFS, ERR_NONE);
      settle();
      chk1(err_ind, 1'b0);
      // fill the buffer, then a command must stall until a pop
      cmd(CMD_OPC_QUERY);
      wait_idle();
      cmd(CMD_OPC_QUERY);
      wait_idle();
      cmd(CMD_OPC);
      settle();
      chk1(cmd_busy, 1'b1);
      take();
      wait_idle();
      take();
      rdc(STATUS_BYTE_OFS, 16'h0000);
      ev.triggered_mode <= 1'b1;
      ev.ops_pending <= 1'b1;
      cmd(CMD_WAIT);
      settle();
      chk1(cmd_busy, 1'b1);
      ev.ops_pending <= 1'b0;
      wait_idle();
      // raise the service flag so the query must keep bit 6 set
      wr(STD_ENABLE_OFS, 16'h0001);
      wr(SERVICE_EN_OFS, 16'h0020);
      cmd(CMD_STB_QUERY);
      wait_idle();
      chk({8'h00, head}, 16'h0060);
      chk1(srq, 1'b1);
      take();
      rdc(4'hf, 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
